// ### hw/hps_top.sv
// Purpose: Strap latch, host pin direction control, interrupt pin and indicators
// Assumes: reset is the power-on reset; phy and protocol inputs are on clk
// Notes:   Pull and buffer enables are level outputs to the pad ring
`timescale 1ns/1ps
`default_nettype none
module hps_top
  import hps_pkg::*;
#(
  parameter bit LARGE_PKG    = 1'b1,
  parameter int STRAP_CYCLES = STRAP_LATCH_CYCLES,
  parameter int STRETCH_CYC  = ACT_STRETCH_CYCLES
) (
  // Clock, reset, enable
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          ce,
  // Straps and shared pins
  input  wire logic [4:0]    parallel_mode_strap,
  input  wire logic          int_pin_in,
  output logic               int_pin_out,
  output logic               int_pin_oe,
  input  wire logic          cs_pin_in,
  output logic               cs_pullup_en,
  output logic               cs_pulldown_en,
  // Interface selection
  output logic               serial_if_en,
  output logic               parallel_if_en,
  output hps_mode_e          psp_mode,
  output hps_pin_ctl_s       psp_pin_ctl,
  output logic [4:0]         strap_ibuf_en,
  // Interrupt source
  input  wire logic          irq_pending,
  // Serial data out
  input  wire logic          so_drive_req,
  input  wire logic          so_data,
  output logic               so_pin_out,
  output logic               so_pin_oe,
  // Parallel address/data
  input  wire logic          psp_read_active,
  input  wire logic [15:0]   psp_rd_data,
  output logic [15:0]        ad_pin_out,
  output logic [15:0]        ad_pin_oe,
  // Indicator configuration and phy status
  input  wire logic          ind_cfg_wr,
  input  wire logic [15:0]   ind_cfg_wdata,
  output logic [15:0]        indicator_control_reg,
  input  wire hps_phy_stat_s phy_stat,
  output logic               link_indicator_out,
  output logic               activity_indicator_out
);

  localparam int SCNT_W = $clog2(STRAP_CYCLES + 1);
  localparam int ACNT_W = $clog2(STRETCH_CYC + 1);

  hps_state_e        state_q;
  logic [SCNT_W-1:0] scnt_q;
  logic [6:0]        pins_sync;
  logic [4:0]        strap_s;
  logic              sel_s;
  logic              cs_s;
  hps_mode_e         mode_d;
  hps_pin_ctl_s      ctl_d;
  logic [1:0]        act;
  logic              bicolor;
  logic              colour_two;
  logic              one_d;
  logic              two_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  hps_sync3 #(.W(7)) u_sync (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .async_in ({cs_pin_in, int_pin_in, parallel_mode_strap}),
    .sync_out (pins_sync)
  );
  assign strap_s = pins_sync[4:0];
  assign sel_s   = pins_sync[5];
  assign cs_s    = pins_sync[6];

  // ----------------------------------------------------------------
  // Strap sampling sequence
  // ----------------------------------------------------------------
  // Sampling waits out the synchroniser since it starts with reset
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= HPS_ST_SAMPLE;
      scnt_q  <= '0;
    end else if (ce) begin
      case (state_q)
        HPS_ST_SAMPLE: begin
          if (scnt_q == SCNT_W'(STRAP_CYCLES - 1)) begin
            state_q <= HPS_ST_RUN;
          end
          scnt_q <= scnt_q + 1'b1;
        end
        HPS_ST_RUN: state_q <= HPS_ST_RUN;
        default: state_q <= HPS_ST_SAMPLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  always_comb begin
    mode_d = HPS_MODE_NONE;
    if (!sel_s) begin
      if (!LARGE_PKG) begin
        mode_d = strap_s[STRAP_SMALL] ? HPS_MODE_6 : HPS_MODE_5;
      end else if (!strap_s[STRAP_MUXED]) begin
        // Strap one doubles as address 14 and is not looked at
        case ({strap_s[STRAP_WIDE], strap_s[STRAP_STROBE]})
          2'b00:   mode_d = HPS_MODE_1;
          2'b01:   mode_d = HPS_MODE_2;
          2'b10:   mode_d = HPS_MODE_3;
          default: mode_d = HPS_MODE_4;
        endcase
      end else begin
        // Strap four doubles as the latch strobe and is not looked at
        case ({strap_s[STRAP_MUX_LO], strap_s[STRAP_WIDE]})
          2'b00:   mode_d = HPS_MODE_5;
          2'b10:   mode_d = HPS_MODE_6;
          2'b01:   mode_d = HPS_MODE_9;
          default: mode_d = HPS_MODE_10;
        endcase
      end
    end
  end

  always_comb begin
    ctl_d = '0;
    case (mode_d)
      HPS_MODE_1, HPS_MODE_2: begin
        ctl_d.addr_en = ADDR_15;
        ctl_d.ad_en   = AD_8;
        ctl_d.ctl_en  = CTL_SEP8;
      end
      HPS_MODE_3, HPS_MODE_4: begin
        ctl_d.addr_en = ADDR_14;
        ctl_d.ad_en   = AD_16;
        ctl_d.ctl_en  = CTL_SEP16;
      end
      HPS_MODE_5, HPS_MODE_6: begin
        ctl_d.ad_en  = AD_15;
        ctl_d.ctl_en = CTL_MUX8;
      end
      HPS_MODE_9, HPS_MODE_10: begin
        ctl_d.ad_en  = AD_16;
        ctl_d.ctl_en = CTL_MUX16;
      end
      default: ctl_d = '0;
    endcase
  end

  // ----------------------------------------------------------------
  // Strap latch, held until the next reset
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      serial_if_en   <= 1'b0;
      parallel_if_en <= 1'b0;
      psp_mode       <= HPS_MODE_NONE;
      psp_pin_ctl    <= '0;
      strap_ibuf_en  <= 5'h1f;
    end else if (ce && state_q == HPS_ST_SAMPLE &&
                 scnt_q == SCNT_W'(STRAP_CYCLES - 1)) begin
      serial_if_en   <= sel_s;
      parallel_if_en <= !sel_s;
      psp_mode       <= mode_d;
      psp_pin_ctl    <= ctl_d;
      // Large package keeps straps two and three alive in serial mode
      strap_ibuf_en  <= (sel_s && LARGE_PKG) ? SERIAL_KEEP : 5'h00;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt pin and chip select pulls
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      int_pin_out <= 1'b1;
      int_pin_oe  <= 1'b0;
    end else if (ce) begin
      int_pin_oe  <= (state_q == HPS_ST_RUN);
      int_pin_out <= !irq_pending;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cs_pullup_en   <= 1'b0;
      cs_pulldown_en <= 1'b0;
    end else if (ce) begin
      cs_pullup_en   <= serial_if_en;
      cs_pulldown_en <= parallel_if_en;
    end
  end

  // ----------------------------------------------------------------
  // Serial data out and parallel address/data drivers
  // ----------------------------------------------------------------
  // The select input is synchronised, so release trails the pin by five clocks
  always_ff @(posedge clk) begin
    if (reset) begin
      so_pin_out <= 1'b0;
      so_pin_oe  <= 1'b0;
    end else if (ce) begin
      so_pin_out <= so_data;
      so_pin_oe  <= serial_if_en && !cs_s && so_drive_req;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ad_pin_out <= '0;
      ad_pin_oe  <= '0;
    end else if (ce) begin
      ad_pin_out <= psp_rd_data & psp_pin_ctl.ad_en;
      if (parallel_if_en && cs_s && psp_read_active) begin
        ad_pin_oe <= psp_pin_ctl.ad_en;
      end else begin
        ad_pin_oe <= '0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Indicators
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      indicator_control_reg <= IND_CTRL_RST;
    end else if (ce && ind_cfg_wr) begin
      indicator_control_reg <= ind_cfg_wdata;
    end
  end

  // Activity stretch keeps a single-clock event visible to the eye
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_act
      logic [ACNT_W-1:0] cnt_q;
      logic              ev;
      assign ev = (g == 0) ? phy_stat.tx_event : phy_stat.rx_event;
      always_ff @(posedge clk) begin
        if (reset) begin
          cnt_q <= '0;
        end else if (ce) begin
          if (ev) begin
            cnt_q <= ACNT_W'(STRETCH_CYC);
          end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
      end
      assign act[g] = ev || (cnt_q != '0);
    end
  endgenerate

  function automatic logic ind_fn(input logic [3:0] code, input logic link,
                                  input logic [1:0] a);
    case (code)
      IND_ON:       ind_fn = 1'b1;
      IND_LINK:     ind_fn = link;
      IND_ACT:      ind_fn = |a;
      IND_TX:       ind_fn = a[0];
      IND_RX:       ind_fn = a[1];
      IND_LINK_ACT: ind_fn = link && !(|a);
      default:      ind_fn = 1'b0;
    endcase
  endfunction

  logic [3:0] cfg_one;
  logic [3:0] cfg_two;
  assign cfg_one = indicator_control_reg[CFG_ONE_LSB +: CFG_W];
  assign cfg_two = indicator_control_reg[CFG_TWO_LSB +: CFG_W];
  assign bicolor = (cfg_one == cfg_two) &&
                   (cfg_one == IND_BICOLOR_FD || cfg_one == IND_BICOLOR_SPD);
  assign colour_two = (cfg_one == IND_BICOLOR_FD) ?
                      (phy_stat.speed_100 && phy_stat.full_duplex) :
                      phy_stat.speed_100;

  always_comb begin
    if (bicolor) begin
      // Traffic blinks the pair dark, colour set by speed, and also by duplex for IND_BICOLOR_FD
      one_d = phy_stat.link_up && !(|act) && !colour_two;
      two_d = phy_stat.link_up && !(|act) && colour_two;
    end else begin
      one_d = ind_fn(cfg_one, phy_stat.link_up, act);
      two_d = ind_fn(cfg_two, phy_stat.link_up, act);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_indicator_out     <= 1'b0;
      activity_indicator_out <= 1'b0;
    end else if (ce) begin
      link_indicator_out     <= one_d;
      activity_indicator_out <= two_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic [SCNT_W:0] age_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      age_q <= '0;
    end else if (ce && age_q <= (SCNT_W+1)'(STRAP_CYCLES)) begin
      age_q <= age_q + 1'b1;
    end
  end

  sequence s_latch_edge;
    ce && state_q == HPS_ST_SAMPLE && scnt_q == SCNT_W'(STRAP_CYCLES - 1);
  endsequence

  sequence s_idle_fast;
    ce && bicolor && phy_stat.link_up && !(|act) &&
    phy_stat.speed_100 && phy_stat.full_duplex;
  endsequence

  AST_LATCH_TIME: assert property (
    age_q == (SCNT_W+1)'(STRAP_CYCLES) && $past(age_q) != (SCNT_W+1)'(STRAP_CYCLES) |->
    (serial_if_en != parallel_if_en) && !$past(serial_if_en || parallel_if_en))
    else $error("strap latched at wrong time");
  AST_LATCH_VALUE: assert property (
    s_latch_edge ##1 1'b1 |-> serial_if_en == $past(sel_s))
    else $error("interface enable does not follow strap");
  AST_ONE_IF: assert property (
    !(serial_if_en && parallel_if_en))
    else $error("both host interfaces enabled");
  AST_STRAP_HOLD: assert property (
    state_q == HPS_ST_RUN && $past(state_q) == HPS_ST_RUN |->
    $stable(psp_mode) && $stable(serial_if_en))
    else $error("latched strap changed");
  AST_INT_HIZ: assert property (
    state_q == HPS_ST_SAMPLE |=> !int_pin_oe)
    else $error("interrupt pin driven while sampling");
  AST_INT_LEVEL: assert property (
    ce && state_q == HPS_ST_RUN |=> int_pin_oe && int_pin_out == !$past(irq_pending))
    else $error("interrupt pin level wrong");
  AST_SO_HIZ: assert property (
    ce && cs_s |=> !so_pin_oe)
    else $error("serial out driven while deselected");
  AST_AD_INPUT: assert property (
    ce && !(cs_s && psp_read_active) |=> ad_pin_oe == '0)
    else $error("address/data driven outside a selected read");
  AST_SERIAL_PSP_OFF: assert property (
    serial_if_en |-> psp_pin_ctl == '0)
    else $error("parallel pins enabled in serial mode");
  AST_BICOLOR_IDLE: assert property (
    s_idle_fast |=> activity_indicator_out && !link_indicator_out)
    else $error("bi-colour idle colour wrong");
  AST_DEFAULT_CFG: assert property (
    $past(reset) |-> indicator_control_reg == IND_CTRL_RST)
    else $error("indicator config not at default after reset");

endmodule
`default_nettype wire

// ### hw/hps_pkg.sv
// Purpose: Shared constants and types for the host port strap and status pins
// Assumes: 100 MHz clk, synchronous active-high reset at power-on
// Notes:   Field positions, reset values, pin masks and timing counts
package hps_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 10;
  localparam int STRAP_LATCH_MIN_NS = 1000;
  localparam int STRAP_LATCH_MAX_NS = 10000;
  // Earliest point of the window, rounded up to whole cycles
  localparam int STRAP_LATCH_CYCLES =
    (STRAP_LATCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACT_STRETCH_NS     = 40000000;
  localparam int ACT_STRETCH_CYCLES = ACT_STRETCH_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Indicator control register
  // ----------------------------------------------------------------
  localparam int          CFG_W           = 4;
  localparam int          CFG_ONE_LSB     = 12;
  localparam int          CFG_TWO_LSB     = 8;
  localparam logic [15:0] IND_CTRL_RST    = 16'h2300;
  localparam logic [3:0]  IND_OFF         = 4'h0;
  localparam logic [3:0]  IND_ON          = 4'h1;
  localparam logic [3:0]  IND_LINK        = 4'h2;
  localparam logic [3:0]  IND_ACT         = 4'h3;
  localparam logic [3:0]  IND_TX          = 4'h4;
  localparam logic [3:0]  IND_RX          = 4'h5;
  localparam logic [3:0]  IND_LINK_ACT    = 4'h6;
  localparam logic [3:0]  IND_BICOLOR_FD  = 4'hf;
  localparam logic [3:0]  IND_BICOLOR_SPD = 4'he;

  // ----------------------------------------------------------------
  // Strap pin positions and pin masks
  // ----------------------------------------------------------------
  localparam int          STRAP_W        = 5;
  localparam int          STRAP_SMALL    = 0;
  localparam int          STRAP_MUX_LO   = 1;
  localparam int          STRAP_WIDE     = 2;
  localparam int          STRAP_MUXED    = 3;
  localparam int          STRAP_STROBE   = 4;
  localparam logic [4:0]  SERIAL_KEEP    = 5'h0c;
  localparam logic [14:0] ADDR_15        = 15'h7fff;
  localparam logic [14:0] ADDR_14        = 15'h3fff;
  localparam logic [15:0] AD_8           = 16'h00ff;
  localparam logic [15:0] AD_15          = 16'h7fff;
  localparam logic [15:0] AD_16          = 16'hffff;
  // Control enables {latch, select, strobe1, strobe2, strobe3}
  localparam logic [4:0]  CTL_SEP8       = 5'h0e;
  localparam logic [4:0]  CTL_SEP16      = 5'h0f;
  localparam logic [4:0]  CTL_MUX8       = 5'h1e;
  localparam logic [4:0]  CTL_MUX16      = 5'h1f;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [8:0] {
    HPS_MODE_NONE = 9'h001,
    HPS_MODE_1    = 9'h002,
    HPS_MODE_2    = 9'h004,
    HPS_MODE_3    = 9'h008,
    HPS_MODE_4    = 9'h010,
    HPS_MODE_5    = 9'h020,
    HPS_MODE_6    = 9'h040,
    HPS_MODE_9    = 9'h080,
    HPS_MODE_10   = 9'h100
  } hps_mode_e;

  typedef enum logic [1:0] {
    HPS_ST_SAMPLE = 2'b01,
    HPS_ST_RUN    = 2'b10
  } hps_state_e;

  typedef struct packed {
    logic [14:0] addr_en;
    logic [15:0] ad_en;
    logic [4:0]  ctl_en;
  } hps_pin_ctl_s;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic tx_event;
    logic rx_event;
  } hps_phy_stat_s;

endpackage

// ### hw/hps_sync3.sv
// Purpose: Three-stage synchroniser for pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   Output follows only once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module hps_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         ce,
  // Data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ----------------------------------------------------------------
  // Stages
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Stage one is read by stage two only; filter looks at two and three
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (reset) begin
          sync_out[i] <= 1'b0;
        end else if (ce && (s2_q[i] == s3_q[i])) begin
          sync_out[i] <= s3_q[i];
        end
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### bench/hps_host_model.sv
// Purpose: Host side of the shared interrupt and chip select pins
// Assumes: One clock; the strap resistor sets the level of an undriven interrupt pin
// Notes:   Chip select with no driver and no pull flips each cycle, never holds a stale value
`timescale 1ns/1ps
`default_nettype none
module hps_host_model (
  // Clock and bench controls
  input  wire logic clk,
  input  wire logic strap_high,
  input  wire logic cs_drive,
  input  wire logic cs_level,
  // Device pins
  input  wire logic int_pin_out,
  input  wire logic int_pin_oe,
  input  wire logic cs_pullup_en,
  input  wire logic cs_pulldown_en,
  output logic      int_wire,
  output logic      cs_wire
);
  logic flip_q = 1'b0;
  always @(posedge clk) begin
    flip_q <= ~flip_q;
  end
  // Host leaves the interrupt line undriven, so only the resistor or the device sets it
  assign int_wire = int_pin_oe ? int_pin_out : strap_high;
  always_comb begin
    if (cs_drive) begin
      cs_wire = cs_level;
    end else if (cs_pullup_en) begin
      cs_wire = 1'b1;
    end else if (cs_pulldown_en) begin
      cs_wire = 1'b0;
    end else begin
      cs_wire = flip_q;
    end
  end
endmodule
`default_nettype wire

// ### bench/host_port_strap_and_status_pins_test.sv
// Purpose: Self-checking bench for the strap latch, pin control and indicators
// Assumes: Short strap and stretch counts of 8 cycles
// Notes:   Each power-up re-latches the straps, so every mode costs one reset
`timescale 1ns/1ps
`default_nettype none
module host_port_strap_and_status_pins_test;
  import hps_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic          clk, reset, strap_high, cs_drive, cs_level, irq_pending;
  logic          so_drive_req, so_data, psp_read_active, ind_cfg_wr, int_wire, cs_wire;
  logic          int_pin_out, int_pin_oe, cs_pullup_en, cs_pulldown_en;
  logic          serial_if_en, parallel_if_en, so_pin_out, so_pin_oe;
  logic          link_indicator_out, activity_indicator_out;
  logic [4:0]    straps, strap_ibuf_en;
  logic [15:0]   psp_rd_data, ad_pin_out, ad_pin_oe, ind_cfg_wdata, indicator_control_reg;
  hps_mode_e     psp_mode, small_mode;
  hps_pin_ctl_s  psp_pin_ctl;
  hps_phy_stat_s phy_stat;
  int            n_errors = 0;
  int            checks_done = 0;
  int            cycles = 0;
  localparam logic [4:0] STRAPS [8] = '{5'h02, 5'h11, 5'h04, 5'h17, 5'h08, 5'h1b, 5'h0c, 5'h0f};
  localparam hps_mode_e  MODES [8] = '{HPS_MODE_1, HPS_MODE_2, HPS_MODE_3, HPS_MODE_4,
                                       HPS_MODE_5, HPS_MODE_6, HPS_MODE_9, HPS_MODE_10};

  hps_top #(.LARGE_PKG(1'b1), .STRAP_CYCLES(8), .STRETCH_CYC(8)) i_hps_top (
    .clk(clk), .reset(reset), .ce(1'b1), .parallel_mode_strap(straps),
    .int_pin_in(int_wire), .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe),
    .cs_pin_in(cs_wire), .cs_pullup_en(cs_pullup_en), .cs_pulldown_en(cs_pulldown_en),
    .serial_if_en(serial_if_en), .parallel_if_en(parallel_if_en), .psp_mode(psp_mode),
    .psp_pin_ctl(psp_pin_ctl), .strap_ibuf_en(strap_ibuf_en), .irq_pending(irq_pending),
    .so_drive_req(so_drive_req), .so_data(so_data), .so_pin_out(so_pin_out),
    .so_pin_oe(so_pin_oe), .psp_read_active(psp_read_active), .psp_rd_data(psp_rd_data),
    .ad_pin_out(ad_pin_out), .ad_pin_oe(ad_pin_oe), .ind_cfg_wr(ind_cfg_wr),
    .ind_cfg_wdata(ind_cfg_wdata), .indicator_control_reg(indicator_control_reg),
    .phy_stat(phy_stat), .link_indicator_out(link_indicator_out),
    .activity_indicator_out(activity_indicator_out));

  // Small package decode sees the same straps; only its mode is judged
  hps_top #(.LARGE_PKG(1'b0), .STRAP_CYCLES(8), .STRETCH_CYC(8)) i_hps_top_small (
    .clk(clk), .reset(reset), .ce(1'b1), .parallel_mode_strap(straps), .int_pin_in(int_wire),
    .int_pin_out(), .int_pin_oe(), .cs_pin_in(cs_wire), .cs_pullup_en(), .cs_pulldown_en(),
    .serial_if_en(), .parallel_if_en(), .psp_mode(small_mode), .psp_pin_ctl(),
    .strap_ibuf_en(), .irq_pending(irq_pending), .so_drive_req(so_drive_req),
    .so_data(so_data), .so_pin_out(), .so_pin_oe(), .psp_read_active(psp_read_active),
    .psp_rd_data(psp_rd_data), .ad_pin_out(), .ad_pin_oe(), .ind_cfg_wr(ind_cfg_wr),
    .ind_cfg_wdata(ind_cfg_wdata), .indicator_control_reg(), .phy_stat(phy_stat),
    .link_indicator_out(), .activity_indicator_out());

  hps_host_model i_hps_host_model (
    .clk(clk), .strap_high(strap_high), .cs_drive(cs_drive), .cs_level(cs_level),
    .int_pin_out(int_pin_out), .int_pin_oe(int_pin_oe), .cs_pullup_en(cs_pullup_en),
    .cs_pulldown_en(cs_pulldown_en), .int_wire(int_wire), .cs_wire(cs_wire));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // A hang costs one mismatch and still ends in the verdict
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic power_up(input logic ser, input logic [4:0] s);
    int n;
    reset = 1'b1;
    strap_high = ser;
    straps = s;
    step(3);
    chk("ibuf_reset", strap_ibuf_en, 5'h1f);
    reset = 1'b0;
    step(2);
    chk("int_oe_sampling", int_pin_oe, 1'b0);
    n = 0;
    while (serial_if_en !== 1'b1 && parallel_if_en !== 1'b1 && n < 40) begin
      step(1);
      n++;
    end
    chk("latch_edge", n + 2, 8);
    step(2);
  endtask
  task automatic cfg_write(input logic [15:0] v);
    ind_cfg_wdata = v;
    ind_cfg_wr = 1'b1;
    step(1);
    ind_cfg_wr = 1'b0;
    step(2);
  endtask
  task automatic leds(input logic one, input logic two);
    chk("link_ind", link_indicator_out, one);
    chk("act_ind", activity_indicator_out, two);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_modes();
    logic [15:0] ad;
    for (int i = 0; i < 8; i++) begin
      ad = (i < 2) ? AD_8 : (i < 4 || i > 5) ? AD_16 : AD_15;
      power_up(1'b0, STRAPS[i]);
      chk("parallel_en", parallel_if_en, 1'b1);
      chk("serial_en", serial_if_en, 1'b0);
      chk("mode", psp_mode, MODES[i]);
      chk("small_mode", small_mode, STRAPS[i][0] ? HPS_MODE_6 : HPS_MODE_5);
      chk("addr_en", psp_pin_ctl.addr_en, (i < 2) ? ADDR_15 : (i < 4) ? ADDR_14 : 15'h0);
      chk("ad_en", psp_pin_ctl.ad_en, ad);
      chk("pulls", {cs_pullup_en, cs_pulldown_en}, 2'b01);
      chk("int_oe", int_pin_oe, 1'b1);
      straps = ~STRAPS[i];
      step(10);
      chk("mode_held", psp_mode, MODES[i]);
    end
    $display("modes done");
  endtask
  task automatic t_ad();
    cs_drive = 1'b1;
    cs_level = 1'b1;
    psp_rd_data = 16'ha5c3;
    psp_read_active = 1'b1;
    step(6);
    chk("ad_oe", ad_pin_oe, AD_16);
    chk("ad_out", ad_pin_out, 16'ha5c3);
    cs_level = 1'b0;
    so_drive_req = 1'b1;
    step(6);
    chk("ad_oe_idle", ad_pin_oe, 16'h0);
    chk("so_oe_parallel", so_pin_oe, 1'b0);
    psp_read_active = 1'b0;
    so_drive_req = 1'b0;
    $display("ad done");
  endtask
  task automatic t_serial();
    power_up(1'b1, 5'h1f);
    chk("serial_en", {serial_if_en, parallel_if_en}, 2'b10);
    chk("mode_none", psp_mode, HPS_MODE_NONE);
    chk("pin_ctl", psp_pin_ctl, 36'h0);
    chk("ibuf", strap_ibuf_en, 5'h0c);
    chk("pulls", {cs_pullup_en, cs_pulldown_en}, 2'b10);
    irq_pending = 1'b1;
    step(1);
    chk("int_low", {int_pin_oe, int_pin_out}, 2'b10);
    irq_pending = 1'b0;
    step(1);
    chk("int_high", {int_pin_oe, int_pin_out}, 2'b11);
    so_drive_req = 1'b1;
    so_data = 1'b1;
    cs_level = 1'b0;
    step(6);
    chk("so_oe", so_pin_oe, 1'b1);
    chk("so_out", so_pin_out, 1'b1);
    cs_level = 1'b1;
    so_data = 1'b0;
    step(6);
    chk("so_oe_deselect", so_pin_oe, 1'b0);
    chk("so_out_low", so_pin_out, 1'b0);
    so_drive_req = 1'b0;
    $display("serial done");
  endtask
  task automatic t_led();
    chk("ind_reset", indicator_control_reg, 16'h2300);
    phy_stat.link_up = 1'b1;
    step(3);
    leds(1'b1, 1'b0);
    phy_stat.rx_event = 1'b1;
    step(1);
    phy_stat.rx_event = 1'b0;
    step(1);
    leds(1'b1, 1'b1);
    step(20);
    leds(1'b1, 1'b0);
    phy_stat.speed_100 = 1'b1;
    phy_stat.full_duplex = 1'b1;
    cfg_write(16'hff00);
    chk("ind_reg", indicator_control_reg, 16'hff00);
    leds(1'b0, 1'b1);
    phy_stat.tx_event = 1'b1;
    step(1);
    phy_stat.tx_event = 1'b0;
    step(1);
    leds(1'b0, 1'b0);
    phy_stat.full_duplex = 1'b0;
    step(20);
    leds(1'b1, 1'b0);
    cfg_write(16'hee00);
    leds(1'b0, 1'b1);
    phy_stat.link_up = 1'b0;
    step(2);
    leds(1'b0, 1'b0);
    cfg_write(16'h4500);
    phy_stat.rx_event = 1'b1;
    step(1);
    phy_stat.rx_event = 1'b0;
    step(1);
    leds(1'b0, 1'b1);
    $display("indicators done");
  endtask

  initial begin
    cs_drive = 1'b0;
    so_data = 1'b0;
    cs_level = 1'b1;
    irq_pending = 1'b0;
    so_drive_req = 1'b0;
    psp_read_active = 1'b0;
    psp_rd_data = 16'h0;
    ind_cfg_wr = 1'b0;
    ind_cfg_wdata = 16'h0;
    phy_stat = '0;
    t_modes();
    t_ad();
    t_serial();
    t_led();
    test_done();
  end
endmodule
`default_nettype wire
